/* File: hdl/lin_timeout_output_compare.sv */
// Purpose: LIN timeout counter, output compare and slave frame tracker
// Assumes: rx/tx pins asynchronous; header strobes from same-clock logic
// Notes:   reproduces the compare-value corruption and header framing fault
`timescale 1ns/1ns
`default_nettype none

module lin_timeout_output_compare
  import lin_to_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              rx_pin,
  input  wire logic              tx_pin,
  input  wire logic              header_done,
  input  wire logic              response_done,
  output logic                   irq,
  output logic                   slave_idle
);
  import lin_to_pkg::*;

  // narrower buses cannot supply the 8-bit offset that both bus paths decode
  if (ADDR_W < 8) begin : g_addr_w_check
    $error("ADDR_W must be at least 8");
  end

  // ==========================================================
  // registers
  logic [2:0]        tcsr_r;
  logic [15:0]       ocr_r;
  logic [15:0]       ocr_nxt;
  logic [ESR_W-1:0]  esr_r;
  logic [ESR_W-1:0]  esr_nxt;
  logic [ESR_W-1:0]  imask_r;
  logic [1:0]        ctrl_r;
  logic [7:0]        cnt_r;
  slave_state_t      state_r;
  slave_state_t      state_nxt;
  logic              lin_started_r;

  // ==========================================================
  // pin synchronisers and activity detect
  // reset to the idle high level so release makes no false edge
  logic [1:0] rx_sync_r;
  logic [1:0] tx_sync_r;
  logic       rx_prev_r;
  logic       tx_prev_r;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rx_sync_r <= 2'h3;
      tx_sync_r <= 2'h3;
      rx_prev_r <= 1'b1;
      tx_prev_r <= 1'b1;
    end else begin
      rx_sync_r <= {rx_sync_r[0], rx_pin};
      tx_sync_r <= {tx_sync_r[0], tx_pin};
      rx_prev_r <= rx_sync_r[1];
      tx_prev_r <= tx_sync_r[1];
    end
  end
  wire pin_activity = (rx_sync_r[1] ^ rx_prev_r) | (tx_sync_r[1] ^ tx_prev_r);

  wire mode_oc    = tcsr_r[TCSR_MODE_BIT];
  wire iot_en     = tcsr_r[TCSR_IOT_BIT];
  wire cnt_en     = tcsr_r[TCSR_CNT_EN];
  wire enabled    = ctrl_r[CTRL_EN_BIT];
  wire uart_mode  = ctrl_r[CTRL_UART_BIT];
  wire lin_active = enabled & ~uart_mode;

  // ==========================================================
  // offset decode, shared by both bus paths
  // count and state are read-only: a write there answers SLVERR
  function automatic logic reg_mapped(input logic [7:0] off, input logic for_write);
    logic hit;
    hit = 1'b0;
    case (off)
      TCSR_OFF, OCR_OFF, ESR_OFF, IMASK_OFF, CTRL_OFF: begin
        hit = 1'b1;
      end
      CNT_OFF, STATE_OFF: begin
        hit = ~for_write;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  // ==========================================================
  // AXI4-Lite write path: address and data taken in either order
  logic              aw_held_r;
  logic              w_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  // the pending response blocks both channels: one write in flight at most
  assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_r & ~s_axi_bvalid;
  wire aw_hs    = s_axi_awvalid & s_axi_awready;
  wire w_hs     = s_axi_wvalid & s_axi_wready;
  wire aw_have  = aw_held_r | aw_hs;
  wire w_have   = w_held_r | w_hs;
  wire wr_go    = aw_have & w_have;
  wire [ADDR_W-1:0] wa = aw_hs ? s_axi_awaddr : awaddr_r;
  wire [31:0]       wd = w_hs ? s_axi_wdata : wdata_r;
  wire [3:0]        ws = w_hs ? s_axi_wstrb : wstrb_r;
  wire [7:0]        wa_off = wa[7:0];
  wire wr_tcsr  = wr_go & (wa_off == TCSR_OFF);
  wire wr_ocr   = wr_go & (wa_off == OCR_OFF);
  wire wr_esr   = wr_go & (wa_off == ESR_OFF);
  wire wr_imask = wr_go & (wa_off == IMASK_OFF);
  wire wr_ctrl  = wr_go & (wa_off == CTRL_OFF);
  wire wr_hit   = reg_mapped(wa_off, 1'b1);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      aw_held_r    <= 1'b0;
      w_held_r     <= 1'b0;
      awaddr_r     <= '0;
      wdata_r      <= 32'h0;
      wstrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else begin
      if (aw_hs && !wr_go) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (w_hs && !wr_go) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // counter and compare
  wire [7:0] oc1_val = ocr_r[OC1_LSB +: 8];
  wire [7:0] oc2_val = ocr_r[OC2_LSB +: 8];
  wire oc_match  = cnt_en & enabled & (cnt_r == oc1_val);
  // stale second compare value trips timeout once LIN traffic starts
  // limitation: not gated by the count enable, so a frozen equal count keeps setting it
  wire to_match  = lin_active & ~mode_oc & lin_started_r & (cnt_r == oc2_val);
  wire hdr_new   = header_done & lin_active;
  // framing fault when a header lands while a response is due
  wire frame_err = hdr_new & (state_r == ST_WAIT_RESP);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_r         <= 8'h0;
      lin_started_r <= 1'b0;
    end else begin
      if (oc_match | hdr_new) begin
        cnt_r <= 8'h0;
      end else if (cnt_en & enabled) begin
        cnt_r <= cnt_r + 8'h1;
      end
      if (!lin_active) begin
        lin_started_r <= 1'b0;
      end else if (hdr_new) begin
        lin_started_r <= 1'b1;
      end
    end
  end

  // ==========================================================
  // compare register: software write then the corruption path
  always_comb begin
    ocr_nxt = ocr_r;
    if (wr_ocr) begin
      if (ws[0]) begin
        ocr_nxt[7:0] = wd[7:0];
      end
      if (ws[1]) begin
        ocr_nxt[15:8] = wd[15:8];
      end
    end
    // UART pin activity disturbs second compare value
    // output compare mode shields it
    // applied after the write, so the disturbance wins a same-cycle clash
    if (enabled && uart_mode && !mode_oc && pin_activity) begin
      ocr_nxt[OC2_LSB +: 8] = oc2_val + 8'h1;
    end
  end

  // ==========================================================
  // slave frame tracking
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (hdr_new) begin
          state_nxt = ST_WAIT_RESP;
        end
      end
      // never entered: a header arrives as a single strobe
      ST_HEADER: begin
        state_nxt = ST_WAIT_RESP;
      end
      ST_WAIT_RESP: begin
        // faulty slave keeps waiting on the first response
        if (response_done) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // first compare match (oc_match) with idle-on-timeout aborts the frame
    if (oc_match && iot_en && !mode_oc) begin
      state_nxt = ST_IDLE;
    end
    if (!lin_active) begin
      state_nxt = ST_IDLE;
    end
  end

  // ==========================================================
  // status: set wins over write-one-to-clear
  logic [ESR_W-1:0] esr_set;
  always_comb begin
    esr_set              = '0;
    esr_set[ESR_OCF_BIT] = oc_match;
    esr_set[ESR_FEF_BIT] = frame_err;
    esr_set[ESR_TOF_BIT] = to_match;
  end
  // an event in the clearing cycle survives, so none is lost
  always_comb begin
    esr_nxt = esr_r;
    if (wr_esr && ws[0]) begin
      esr_nxt = esr_r & ~wd[ESR_W-1:0];
    end
    esr_nxt = esr_nxt | esr_set;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tcsr_r <= TCSR_RST;
    end else if (wr_tcsr && ws[0]) begin
      tcsr_r <= wd[2:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      imask_r <= '0;
      ctrl_r  <= CTRL_RST;
    end else begin
      if (wr_imask && ws[0]) begin
        imask_r <= wd[ESR_W-1:0];
      end
      if (wr_ctrl && ws[0]) begin
        ctrl_r <= wd[1:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ocr_r   <= OCR_RST;
      esr_r   <= '0;
      state_r <= ST_IDLE;
    end else begin
      ocr_r   <= ocr_nxt;
      esr_r   <= esr_nxt;
      state_r <= state_nxt;
    end
  end

  assign irq        = |(esr_r & imask_r);
  assign slave_idle = (state_r == ST_IDLE);

  // ==========================================================
  // AXI4-Lite read path
  wire [7:0] ra_off = s_axi_araddr[7:0];
  wire         rd_hit = reg_mapped(ra_off, 1'b0);
  logic [31:0] rd_mux;
  always_comb begin
    case (ra_off)
      TCSR_OFF:  rd_mux = {29'h0, tcsr_r};
      OCR_OFF:   rd_mux = {16'h0, ocr_r};
      ESR_OFF:   rd_mux = {29'h0, esr_r};
      IMASK_OFF: rd_mux = {29'h0, imask_r};
      CTRL_OFF:  rd_mux = {30'h0, ctrl_r};
      CNT_OFF:   rd_mux = {24'h0, cnt_r};
      STATE_OFF: rd_mux = {30'h0, state_r};
      default: begin
        rd_mux = 32'h0;
      end
    endcase
  end
  assign s_axi_arready = ~s_axi_rvalid;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

`default_nettype wire

/* File: hdl/lin_to_pkg.sv */
// Purpose: shared constants for the timeout / output-compare block
// Assumes: AXI4-Lite register access, 32-bit data, byte addresses
// Notes:   offsets below are word aligned
package lin_to_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] TCSR_OFF   = 8'h00;
  localparam logic [7:0] OCR_OFF    = 8'h04;
  localparam logic [7:0] ESR_OFF    = 8'h08;
  localparam logic [7:0] IMASK_OFF  = 8'h0C;
  localparam logic [7:0] CTRL_OFF   = 8'h10;
  localparam logic [7:0] CNT_OFF    = 8'h14;
  localparam logic [7:0] STATE_OFF  = 8'h18;
  // ==========================================================
  // timeout_control_status_reg fields
  localparam int TCSR_MODE_BIT = 0;
  localparam int TCSR_IOT_BIT  = 1;
  localparam int TCSR_CNT_EN   = 2;
  // output_compare_reg fields
  localparam int OC1_LSB = 0;
  localparam int OC2_LSB = 8;
  // lin_error_status_reg / mask fields
  localparam int ESR_OCF_BIT = 0;
  localparam int ESR_FEF_BIT = 1;
  localparam int ESR_TOF_BIT = 2;
  localparam int ESR_W       = 3;
  // control register fields
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_UART_BIT = 1;
  // ==========================================================
  // reset values
  localparam logic [2:0]  TCSR_RST = 3'h0;
  localparam logic [15:0] OCR_RST  = 16'hFFFF;
  localparam logic [1:0]  CTRL_RST = 2'h0;
  // timing
  localparam int BIT_TIME_NS = 40;
  localparam int CLK_NS      = 40;
  localparam int BIT_CYC     = (BIT_TIME_NS + CLK_NS - 1) / CLK_NS;
  // slave frame states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_HEADER,
    ST_WAIT_RESP
  } slave_state_t;
endpackage

/* File: verification/lin_master_model.sv */
// Purpose: LIN master and pin activity
// Assumes: pins idle high between frames
// Notes:   header and response are one-cycle strobes
`timescale 1ns/1ns
`default_nettype none
module lin_master_model (
  input  wire logic clock,
  input  wire logic irq,
  output logic      rx_pin,
  output logic      tx_pin,
  output logic      header_done,
  output logic      response_done
);
  initial begin
    rx_pin = 1'b1;
    tx_pin = 1'b1;
    header_done = 1'b0;
    response_done = 1'b0;
  end
  // spaced wider than the synchroniser
  task automatic pin_edges(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge clock);
      if (i % 2 == 1) tx_pin <= ~tx_pin;
      else rx_pin <= ~rx_pin;
    end
    repeat (6) @(posedge clock);
  endtask
  task automatic pulse(input logic resp);
    @(posedge clock);
    if (resp) response_done <= 1'b1;
    else header_done <= 1'b1;
    @(posedge clock);
    response_done <= 1'b0;
    header_done <= 1'b0;
  endtask
  task automatic header_after_flag();
    while (irq !== 1'b1) @(posedge clock);
    pulse(1'b0);
  endtask
endmodule
`default_nettype wire

/* File: verification/lin_to_sva.sv */
// Purpose: port checks of the timeout block
// Assumes: one clock, rst_n synchronous
// Notes:   sees only top-level ports
`timescale 1ns/1ns
`default_nettype none
module lin_to_sva #(
  parameter int ADDR_W = 8
) (
  input wire logic              clock,
  input wire logic              rst_n,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              header_done,
  input wire logic              irq,
  input wire logic              slave_idle
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // bus handshakes
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_bad;
    s_axi_arvalid && s_axi_arready && (s_axi_araddr > 8'h18);
  endsequence
  AST_WR_ANS: assert property (s_wr_take |=> s_axi_bvalid)
    else $error("no write response");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_B_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  AST_RD_BAD: assert property (s_rd_bad |=> s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read answer wrong");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_R_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  // ==========================================================
  // reset state and header acceptance
  AST_RST_IDLE: assert property ($rose(rst_n) |-> slave_idle && !irq && !s_axi_bvalid)
    else $error("not idle after reset");
  AST_HDR_BUSY: assert property (slave_idle && header_done |=> !slave_idle)
    else $error("header not accepted");
endmodule
bind lin_timeout_output_compare lin_to_sva #(.ADDR_W(ADDR_W)) u_lin_to_sva (.*);
`default_nettype wire

/* File: verification/testbench.sv */
// Purpose: self-checking bench of the timeout block
// Assumes: 25 MHz clock, synchronous reset
// Notes:   scenarios run in fixed order
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import lin_to_pkg::*;
  logic        clock, rst_n, irq, slave_idle, rx_pin, tx_pin, header_done, response_done;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp_q;
  int          err_count = 0;
  int          checks = 0;
  lin_timeout_output_compare u_lin_timeout_output_compare (.*);
  lin_master_model u_lin_master_model (.*);
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // ==========================================================
  // bus tasks
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st = 4'hF);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    do @(posedge clock); while (s_axi_bvalid !== 1'b1);
    resp_q = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clock); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock); while (s_axi_rvalid !== 1'b1);
    rd_q = s_axi_rdata;
    resp_q = s_axi_rresp;
    s_axi_rready <= 1'b0;
    cmp(what, exp, rd_q);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    chk("tcsr", TCSR_OFF, 32'h0);
    chk("ocr", OCR_OFF, 32'h0000FFFF);
    wr(OCR_OFF, 32'h0000AB12, 4'h1);
    chk("ocr lane", OCR_OFF, 32'h0000FF12);
    wr(CNT_OFF, 32'h0);
    cmp("ro bresp", 32'h2, {30'h0, resp_q});
    chk("unmapped", 8'h1C, 32'h0);
    cmp("rresp", 32'h2, {30'h0, resp_q});
    wr(8'h1C, 32'h0);
    cmp("bresp", 32'h2, {30'h0, resp_q});
  endtask
  task automatic t_corrupt();
    wr(OCR_OFF, 32'h00000010);
    wr(CTRL_OFF, 32'h3);
    u_lin_master_model.pin_edges(4);
    chk("oc2 drift", OCR_OFF, 32'h00000410);
    wr(TCSR_OFF, 32'h1);
    u_lin_master_model.pin_edges(4);
    chk("oc2 held", OCR_OFF, 32'h00000410);
  endtask
  task automatic t_spurious();
    wr(IMASK_OFF, 32'h4);
    wr(TCSR_OFF, 32'h4);
    wr(CTRL_OFF, 32'h1);
    u_lin_master_model.pulse(1'b0);
    for (int i = 0; i < 200 && irq !== 1'b1; i++) @(posedge clock);
    cmp("timeout irq", 32'h1, {31'h0, irq});
    wr(TCSR_OFF, 32'h0);
    wr(ESR_OFF, 32'h7);
    chk("esr clear", ESR_OFF, 32'h0);
    cmp("irq clear", 32'h0, {31'h0, irq});
    u_lin_master_model.pulse(1'b1);
    repeat (2) @(posedge clock);
    cmp("frame idle", 32'h1, {31'h0, slave_idle});
  endtask
  task automatic t_headers();
    u_lin_master_model.pulse(1'b0);
    u_lin_master_model.pulse(1'b0);
    chk("esr", ESR_OFF, 32'h2);
    cmp("framing", 32'h2, rd_q & 32'h2);
    cmp("still busy", 32'h0, {31'h0, slave_idle});
    chk("state", STATE_OFF, 32'h2);
    chk("cnt", CNT_OFF, 32'h0);
    wr(ESR_OFF, 32'h7);
    wr(IMASK_OFF, 32'h1);
    wr(TCSR_OFF, 32'h6);
    u_lin_master_model.header_after_flag();
    chk("esr", ESR_OFF, 32'h5);
    cmp("recovered", 32'h1, rd_q & 32'h3);
  endtask
  task automatic conclude();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    conclude();
  end
  initial begin
    rst_n = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_corrupt();
    t_spurious();
    t_headers();
    conclude();
  end
endmodule
`default_nettype wire
